// >>> pcvc_host_model.sv
// Host configuration master model for the register bus
`timescale 1ns/10ps
`default_nettype none
module pcvc_host_model (
  input wire logic clock, // Core clock
  output logic cfgReadEn, // Read strobe
  output logic cfgWriteEn, // Write strobe
  output logic [11:0] cfgAddr, // Byte address
  output logic [31:0] cfgWriteData, // Write data
  output logic [3:0] cfgByteEnable, // Byte enables
  input wire logic [31:0] cfgReadData, // Read data
  input wire logic cfgReadValid // Read data valid
);
  // ************
  // Bus idle state at time zero
  // ************
  initial begin
    cfgReadEn = 1'b0;
    cfgWriteEn = 1'b0;
    cfgAddr = 12'h000;
    cfgWriteData = 32'h00000000;
    cfgByteEnable = 4'h0;
  end
  // One write; data shows its inverse once released so stale values never match
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clock);
    cfgWriteEn <= 1'b1;
    cfgAddr <= a;
    cfgWriteData <= d;
    cfgByteEnable <= be;
    @(posedge clock);
    cfgWriteEn <= 1'b0;
    cfgWriteData <= ~d;
    cfgByteEnable <= ~be;
  endtask : wr
  // One read; answer is taken mid-cycle while valid stands, unknown if not valid
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clock);
    cfgReadEn <= 1'b1;
    cfgAddr <= a;
    @(posedge clock);
    cfgReadEn <= 1'b0;
    cfgAddr <= ~a;
    @(negedge clock);
    d = (cfgReadValid === 1'b1) ? cfgReadData : 32'hXXXXXXXX;
  endtask : rd
endmodule : pcvc_host_model
`default_nettype wire

// >>> pcvc_pkg.sv
// Constants and types shared by the virtual channel capability register block
package pcvc_pkg;

  // ************************************************************
  // Register byte offsets in configuration space
  // ************************************************************
  localparam logic [11:0] PCVC_HEADER_OFS = 12'h140;   // Capability header
  localparam logic [11:0] PCVC_CAP1_OFS = 12'h144;     // Port VC capability one
  localparam logic [11:0] PCVC_CAP2_OFS = 12'h148;     // Port VC capability two
  localparam logic [11:0] PCVC_CTRL_OFS = 12'h14C;     // Arbitration control and status
  localparam logic [11:0] PCVC_TABLE_OFS = 12'h160;    // Arbitration table window
  localparam int PCVC_TABLE_WORDS = 4;                 // 32 phases of 4 bits

  // ************************************************************
  // Fixed field values and reset values
  // ************************************************************
  localparam logic [15:0] PCVC_EXT_CAP_ID = 16'h0002;  // Virtual channel capability
  localparam logic [3:0] PCVC_CAP_VERSION = 4'h1;      // Capability version
  localparam logic [11:0] PCVC_NEXT_CAP_PTR = 12'h20C; // Power budgeting structure
  localparam logic [2:0] PCVC_EXT_VC_COUNT = 3'h0;     // Default channel only
  localparam logic [2:0] PCVC_LOW_PRIORITY_VC_GROUP_RESET = 3'h0;       // Low priority group count
  localparam logic [1:0] PCVC_REF_CLOCK_100NS = 2'h0;  // 100 ns time base code
  localparam logic [1:0] PCVC_ENTRY_SIZE_4BIT = 2'h2;  // Four-bit table entries
  localparam logic [7:0] PCVC_ARB_CAP_RESET = 8'h00;   // Arbitration capability
  localparam logic [7:0] PCVC_TABLE_OFS_RESET = 8'h00; // Table offset in 16-byte units
  localparam logic [2:0] PCVC_SELECT_RESET = 3'h0;     // Default scheme
  localparam logic [2:0] PCVC_SELECT_MAX = 3'h1;       // Highest legal scheme

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int PCVC_ID_LSB = 0;       // Capability identifier
  localparam int PCVC_VER_LSB = 16;     // Capability version
  localparam int PCVC_NEXT_LSB = 20;    // Next pointer
  localparam int PCVC_EXTVC_LSB = 0;    // Extended VC count
  localparam int PCVC_LOW_PRIORITY_VC_GROUP_LSB = 4;     // Low priority VC count
  localparam int PCVC_REFCLK_LSB = 8;   // Reference clock
  localparam int PCVC_ENTRY_LSB = 10;   // Table entry size
  localparam int PCVC_ARBCAP_LSB = 0;   // Arbitration capability
  localparam int PCVC_TBLOFS_LSB = 24;  // Arbitration table offset
  localparam int PCVC_LOAD_BIT = 0;     // Load table command
  localparam int PCVC_SELECT_LSB = 1;   // Arbitration select
  localparam int PCVC_STATUS_BIT = 16;  // Table status

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    PCVC_REG_NONE,
    PCVC_REG_HEADER,
    PCVC_REG_CAP1,
    PCVC_REG_CAP2,
    PCVC_REG_CTRL,
    PCVC_REG_TABLE
  } pcvc_reg_t;                         // Decoded register target

  typedef enum logic [1:0] {
    PCVC_LOAD_IDLE,
    PCVC_LOAD_READ,
    PCVC_LOAD_DRAIN
  } pcvc_load_t;                        // Table loader states

endpackage : pcvc_pkg

// >>> pcvc_regs.sv
// Virtual channel capability header and port arbitration registers
//
// Behaviour
// [R01] Header bits 15:0 read capability id 0002h
// [R02] Header bits 19:16 read version one
// [R03] Header bits 31:20 point to 20Ch
// [R04] Extended VC count reads zero
// [R05] Low priority count resets zero, loadable externally
// [R06] Reference clock code selects 100 ns
// [R07] Entry size code says four bits
// [R08] Arbitration capability field resets to zero
// [R09] Table offset in 16-byte units, zero
// [R10] Load bit applies table, reads zero
// [R11] Select accepts zero or one only
// [R12] Table write sets status bit 16
// [R13] Finished load clears status bit 16
// [R14] Registers exist only in upstream port
// [R15] Read-only writes ignored, reserved reads zero
`timescale 1ns/10ps
`default_nettype none
module pcvc_regs
  import pcvc_pkg::*;
#(
  parameter bit UPSTREAM_PORT = 1'b1,         // Instance sits in the upstream port
  parameter int TABLE_WORDS = PCVC_TABLE_WORDS // Arbitration table words
) (
  input wire logic clock,                          // Core clock, 125 MHz
  input wire logic reset,                          // Synchronous reset, active high
  input wire logic cfgReadEn,                      // Configuration read strobe
  input wire logic cfgWriteEn,                     // Configuration write strobe
  input wire logic [11:0] cfgAddr,                 // Byte address, word aligned
  input wire logic [31:0] cfgWriteData,            // Write data
  input wire logic [3:0] cfgByteEnable,            // Write byte enables
  input wire logic lpvcLoadEn,                     // Management or EEPROM load strobe
  input wire logic [2:0] lpvcLoadValue,            // New low priority group count
  output logic [31:0] cfgReadData,                 // Registered read data
  output logic cfgReadValid,                       // Read data valid pulse
  output logic [2:0] arbScheme,                    // Selected arbitration scheme
  output logic [TABLE_WORDS*32-1:0] activeArbTable, // Arbitration table in use
  output logic tableLoadDone                       // Table load finished pulse
);

  localparam int IDXW = $clog2(TABLE_WORDS);       // Table index width
  localparam logic [11:0] TABLE_END = 12'(PCVC_TABLE_OFS + 12'(TABLE_WORDS * 4)); // Window end

  // ************************************************************
  // Address decode
  // ************************************************************

  // Maps a byte address onto a register of this block
  function automatic pcvc_reg_t decodeReg(input logic [11:0] addr);
    pcvc_reg_t hit;
    hit = PCVC_REG_NONE;
    if (UPSTREAM_PORT) begin  // R14
      if ({addr[11:2], 2'b00} == PCVC_HEADER_OFS) begin
        hit = PCVC_REG_HEADER;
      end else if ({addr[11:2], 2'b00} == PCVC_CAP1_OFS) begin
        hit = PCVC_REG_CAP1;
      end else if ({addr[11:2], 2'b00} == PCVC_CAP2_OFS) begin
        hit = PCVC_REG_CAP2;
      end else if ({addr[11:2], 2'b00} == PCVC_CTRL_OFS) begin
        hit = PCVC_REG_CTRL;
      end else if (addr >= PCVC_TABLE_OFS && addr < TABLE_END) begin
        hit = PCVC_REG_TABLE;
      end
    end
    return hit;
  endfunction : decodeReg

  pcvc_reg_t readHit;                 // Target of the read
  pcvc_reg_t writeHit;                // Target of the write
  logic tableWrite;                   // Software writes a table entry
  logic ctrlWrite;                    // Software writes the low control byte
  logic loadRequest;                  // Load command written
  logic loaderBusy;                   // Loader is walking the table
  logic loaderDone;                   // Loader finished
  logic memReadEn;                    // Loader read strobe
  logic [IDXW-1:0] memReadAddr;       // Loader read index
  logic [31:0] memReadData;           // Stored table word
  logic [IDXW-1:0] tableIndex;        // Word index of a table write
  logic [TABLE_WORDS*32-1:0] loaderTable; // Table from the loader

  assign readHit = decodeReg(cfgAddr);
  assign writeHit = decodeReg(cfgAddr);
  assign tableWrite = cfgWriteEn && (writeHit == PCVC_REG_TABLE) && (cfgByteEnable != 4'h0);
  assign ctrlWrite = cfgWriteEn && (writeHit == PCVC_REG_CTRL) && cfgByteEnable[0];
  assign loadRequest = ctrlWrite && cfgWriteData[PCVC_LOAD_BIT];  // R10
  assign tableIndex = IDXW'((cfgAddr - PCVC_TABLE_OFS) >> 2);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [2:0] low_priority_vc_group;                 // Low priority group count
    logic [2:0] arbSelect;            // Arbitration scheme
    logic tableStatus;                // Table written, not yet loaded
    logic [31:0] rdData;              // Read data register
    logic rdValid;                    // Read data valid
  } pcvc_regs_state_t;

  pcvc_regs_state_t state_r;          // Registered state
  pcvc_regs_state_t state_nxt;        // Next state

  // Register reads and writes
  always_comb begin
    state_nxt = state_r;
    state_nxt.rdValid = cfgReadEn;
    // External default override of the group count
    if (lpvcLoadEn) begin
      state_nxt.low_priority_vc_group = lpvcLoadValue;  // R05
    end
    // Scheme select, illegal codes fall back to the default
    if (ctrlWrite) begin
      if (cfgWriteData[PCVC_SELECT_LSB +: 3] <= PCVC_SELECT_MAX) begin
        state_nxt.arbSelect = cfgWriteData[PCVC_SELECT_LSB +: 3];  // R11
      end else begin
        state_nxt.arbSelect = PCVC_SELECT_RESET;  // R11
      end
    end
    // Table status: a write in the finishing cycle keeps it set
    if (loaderDone) begin
      state_nxt.tableStatus = 1'b0;  // R13
    end
    if (tableWrite) begin
      state_nxt.tableStatus = 1'b1;  // R12
    end
    // Read data mux, anything unmapped reads zero
    if (cfgReadEn) begin
      state_nxt.rdData = 32'h0000_0000;  // R15
      unique case (readHit)
        PCVC_REG_HEADER: begin
          state_nxt.rdData[PCVC_ID_LSB +: 16] = PCVC_EXT_CAP_ID;  // R01
          state_nxt.rdData[PCVC_VER_LSB +: 4] = PCVC_CAP_VERSION;  // R02
          state_nxt.rdData[PCVC_NEXT_LSB +: 12] = PCVC_NEXT_CAP_PTR;  // R03
        end
        PCVC_REG_CAP1: begin
          state_nxt.rdData[PCVC_EXTVC_LSB +: 3] = PCVC_EXT_VC_COUNT;  // R04
          state_nxt.rdData[PCVC_LOW_PRIORITY_VC_GROUP_LSB +: 3] = state_r.low_priority_vc_group;  // R05
          state_nxt.rdData[PCVC_REFCLK_LSB +: 2] = PCVC_REF_CLOCK_100NS;  // R06
          state_nxt.rdData[PCVC_ENTRY_LSB +: 2] = PCVC_ENTRY_SIZE_4BIT;  // R07
        end
        PCVC_REG_CAP2: begin
          state_nxt.rdData[PCVC_ARBCAP_LSB +: 8] = PCVC_ARB_CAP_RESET;  // R08
          state_nxt.rdData[PCVC_TBLOFS_LSB +: 8] = PCVC_TABLE_OFS_RESET;  // R09
        end
        PCVC_REG_CTRL: begin
          state_nxt.rdData[PCVC_LOAD_BIT] = 1'b0;  // R10
          state_nxt.rdData[PCVC_SELECT_LSB +: 3] = state_r.arbSelect;
          state_nxt.rdData[PCVC_STATUS_BIT] = state_r.tableStatus;
        end
        PCVC_REG_TABLE: begin
          state_nxt.rdData = 32'h0000_0000;  // Table window is write only
        end
        PCVC_REG_NONE: begin
          state_nxt.rdData = 32'h0000_0000;  // R14
        end
        default: begin
          state_nxt.rdData = 32'h0000_0000;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= '{low_priority_vc_group: PCVC_LOW_PRIORITY_VC_GROUP_RESET, arbSelect: PCVC_SELECT_RESET, default: '0};
    end else begin
      state_r <= state_nxt;
    end
  end

  // ************************************************************
  // Arbitration table storage and loader
  // ************************************************************

  // Software-programmed table
  pcvc_table_ram #(
    .WIDTH(32),
    .DEPTH(TABLE_WORDS)
  ) u_table_ram (
    .clock(clock),
    .reset(reset),
    .writeEn(tableWrite),  // R12
    .writeAddr(tableIndex),
    .writeData(cfgWriteData),
    .writeByteEn(cfgByteEnable),
    .readEn(memReadEn),
    .readAddr(memReadAddr),
    .readData(memReadData)
  );

  // Copies the stored table into the active table on request
  pcvc_table_loader #(
    .WIDTH(32),
    .WORDS(TABLE_WORDS)
  ) u_table_loader (
    .clock(clock),
    .reset(reset),
    .start(loadRequest),  // R10
    .memReadEn(memReadEn),
    .memReadAddr(memReadAddr),
    .memReadData(memReadData),
    .activeTable(loaderTable),
    .busy(loaderBusy),
    .done(loaderDone)
  );

  // ************************************************************
  // Outputs
  // ************************************************************
  assign cfgReadData = state_r.rdData;
  assign cfgReadValid = state_r.rdValid;
  assign arbScheme = state_r.arbSelect;
  assign activeArbTable = loaderTable;
  assign tableLoadDone = loaderDone;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // Header word content
  a_header_read: assert property (
    cfgReadEn && readHit == PCVC_REG_HEADER |=> cfgReadValid &&
      cfgReadData == {12'h20C, 4'h1, 16'h0002})  // R01 R02 R03
    else $error("header read wrong");

  // First capability word content
  a_cap_one_read: assert property (
    cfgReadEn && readHit == PCVC_REG_CAP1 |=>
      cfgReadData[31:8] == 24'h000008 && cfgReadData[3:0] == 4'h0 &&
      cfgReadData[7] == 1'b0 && cfgReadData[6:4] == $past(state_r.low_priority_vc_group))  // R04 R05 R06 R07
    else $error("capability one read wrong");

  // Second capability word reads zero
  a_cap_two_read: assert property (
    cfgReadEn && readHit == PCVC_REG_CAP2 |=> cfgReadData == 32'h0000_0000)  // R08 R09
    else $error("capability two read wrong");

  // Load bit never reads back set
  a_load_reads_zero: assert property (
    cfgReadEn && readHit == PCVC_REG_CTRL |=> cfgReadData[0] == 1'b0 &&
      cfgReadData[31:17] == 15'h0000 && cfgReadData[15:4] == 12'h000)  // R10
    else $error("control read shows load bit");

  // Load request finishes in bounded time
  a_load_finishes: assert property (
    loadRequest && !loaderBusy |-> ##[1:8] loaderDone)  // R10
    else $error("table load never finished");

  // Illegal scheme codes fall back to the default
  a_select_legal: assert property (
    ctrlWrite && cfgWriteData[3:1] > 3'h1 |=> arbScheme == 3'h0)  // R11
    else $error("illegal scheme kept");

  // Table write sets status
  a_status_set: assert property (
    tableWrite |=> state_r.tableStatus)  // R12
    else $error("status not set by table write");

  // Finished load clears status unless written again
  a_status_clear: assert property (
    loaderDone && !tableWrite |=> !state_r.tableStatus)  // R13
    else $error("status not cleared after load");

  // Group count changes only by external load
  a_low_priority_vc_group_stable: assert property (
    !lpvcLoadEn |=> $stable(state_r.low_priority_vc_group))  // R05 R15
    else $error("group count changed without load");

  // Unmapped reads return zero
  a_unmapped_zero: assert property (
    cfgReadEn && readHit == PCVC_REG_NONE |=> cfgReadData == 32'h0000_0000)  // R14 R15
    else $error("unmapped read not zero");

  // Main scenarios
  c_table_load: cover property (tableWrite ##[1:4] loadRequest ##[1:8] loaderDone);
  c_select_write: cover property (ctrlWrite && cfgWriteData[3:1] == 3'h1);
  c_write_during_done: cover property (loaderDone && tableWrite);

endmodule : pcvc_regs
`default_nettype wire

// >>> pcvc_table_loader.sv
// Sequencer that copies the stored arbitration table into the active table
`timescale 1ns/10ps
`default_nettype none
module pcvc_table_loader
  import pcvc_pkg::*;
#(
  parameter int WIDTH = 32,   // Word width
  parameter int WORDS = 4     // Words in the table
) (
  input wire logic clock,                              // Core clock
  input wire logic reset,                              // Synchronous reset
  input wire logic start,                              // Load request pulse
  output logic memReadEn,                              // Storage read strobe
  output logic [$clog2(WORDS)-1:0] memReadAddr,        // Storage read index
  input wire logic [WIDTH-1:0] memReadData,            // Storage read data
  output logic [WORDS*WIDTH-1:0] activeTable,          // Table in use
  output logic busy,                                   // Load in progress
  output logic done                                    // Load finished pulse
);

  localparam int IDXW = $clog2(WORDS);                 // Index width
  localparam logic [IDXW-1:0] LAST_IDX = IDXW'(WORDS - 1); // Final word

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    pcvc_load_t phase;                 // Sequencer phase
    logic [IDXW-1:0] issueIdx;         // Word being read
    logic [IDXW-1:0] captIdx;          // Word being captured
    logic pending;                     // Read data arrives now
    logic [WORDS*WIDTH-1:0] actTable;  // Active table
    logic done;                        // Finish pulse
  } pcvc_loader_state_t;

  pcvc_loader_state_t state_r;         // Registered state
  pcvc_loader_state_t state_nxt;       // Next state

  // Walk the words, capture each one a cycle after its read
  always_comb begin
    state_nxt = state_r;
    state_nxt.done = 1'b0;
    state_nxt.pending = 1'b0;
    if (state_r.pending) begin
      state_nxt.actTable[state_r.captIdx*WIDTH +: WIDTH] = memReadData;
    end
    unique case (state_r.phase)
      PCVC_LOAD_IDLE: begin
        if (start) begin
          state_nxt.phase = PCVC_LOAD_READ;
          state_nxt.issueIdx = '0;
        end
      end
      PCVC_LOAD_READ: begin
        state_nxt.pending = 1'b1;
        state_nxt.captIdx = state_r.issueIdx;
        if (state_r.issueIdx == LAST_IDX) begin
          state_nxt.phase = PCVC_LOAD_DRAIN;
        end else begin
          state_nxt.issueIdx = state_r.issueIdx + 1'b1;
        end
      end
      PCVC_LOAD_DRAIN: begin
        state_nxt.phase = PCVC_LOAD_IDLE;
        state_nxt.done = 1'b1;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= '{phase: PCVC_LOAD_IDLE, default: '0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign memReadEn = (state_r.phase == PCVC_LOAD_READ);
  assign memReadAddr = state_r.issueIdx;
  assign activeTable = state_r.actTable;
  assign busy = (state_r.phase != PCVC_LOAD_IDLE);
  assign done = state_r.done;

endmodule : pcvc_table_loader
`default_nettype wire

// >>> pcvc_table_ram.sv
// Small storage for the programmed arbitration table with registered read data
`timescale 1ns/10ps
`default_nettype none
module pcvc_table_ram
  import pcvc_pkg::*;
#(
  parameter int WIDTH = 32,   // Word width
  parameter int DEPTH = 4     // Number of words
) (
  input wire logic clock,                              // Core clock
  input wire logic reset,                              // Synchronous reset
  input wire logic writeEn,                            // Write strobe
  input wire logic [$clog2(DEPTH)-1:0] writeAddr,      // Write word index
  input wire logic [WIDTH-1:0] writeData,              // Write data
  input wire logic [WIDTH/8-1:0] writeByteEn,          // Byte enables
  input wire logic readEn,                             // Read strobe
  input wire logic [$clog2(DEPTH)-1:0] readAddr,       // Read word index
  output logic [WIDTH-1:0] readData                    // Registered read data
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;  // Table words
    logic [WIDTH-1:0] rdData;          // Read data register
  } pcvc_ram_state_t;

  pcvc_ram_state_t state_r;            // Registered state
  pcvc_ram_state_t state_nxt;          // Next state

  // Byte-wise write and registered read
  always_comb begin
    state_nxt = state_r;
    if (writeEn) begin
      for (int b = 0; b < WIDTH / 8; b++) begin
        if (writeByteEn[b]) begin
          state_nxt.mem[writeAddr][b*8 +: 8] = writeData[b*8 +: 8];
        end
      end
    end
    if (readEn) begin
      state_nxt.rdData = state_r.mem[readAddr];
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign readData = state_r.rdData;

endmodule : pcvc_table_ram
`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench for the virtual channel capability registers
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pcvc_pkg::*;
  logic clock = 1'b0; // Core clock
  logic reset = 1'b1; // Synchronous reset
  logic rdEn, wrEn, lpEn = 1'b0, valid, done; // Strobes
  logic [11:0] addr; // Address
  logic [31:0] wdata, rdata, v; // Data
  logic [3:0] be; // Byte enables
  logic [2:0] lpVal = 3'h0, scheme; // Count and scheme
  logic [127:0] activeTbl; // Active table
  int miscompares = 0; // Mismatch count
  int checked = 0; // Comparison count
  always #4 clock = ~clock;
  pcvc_host_model host (.clock(clock), .cfgReadEn(rdEn), .cfgWriteEn(wrEn),
    .cfgAddr(addr), .cfgWriteData(wdata), .cfgByteEnable(be),
    .cfgReadData(rdata), .cfgReadValid(valid));
  pcvc_regs dut (.clock(clock), .reset(reset), .cfgReadEn(rdEn), .cfgWriteEn(wrEn),
    .cfgAddr(addr), .cfgWriteData(wdata), .cfgByteEnable(be), .lpvcLoadEn(lpEn),
    .lpvcLoadValue(lpVal), .cfgReadData(rdata), .cfgReadValid(valid),
    .arbScheme(scheme), .activeArbTable(activeTbl), .tableLoadDone(done));
  // Compare one value
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  // Print counts and verdict
  task automatic complete_run;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // Reset values and an unmapped read
  task automatic t_reset;
    host.rd(12'h140, v); chk(v[15:0], 16'h0002);
    chk(v[19:16], 4'h1);
    chk(v[31:20], 12'h20C);
    host.rd(12'h144, v); chk(v[2:0], 3'h0);
    chk(v[6:4], 3'h0);
    chk(v[9:8], 2'h0);
    chk(v[11:10], 2'h2);
    chk({v[31:12], v[7], v[3]}, 22'h000000);
    host.rd(12'h148, v); chk(v[7:0], 8'h00);
    chk(v[31:24], 8'h00);
    host.rd(12'h14C, v); chk(v, 32'h00000000);
    host.rd(12'h150, v); chk(v, 32'h00000000);
    $display("test reset done");
  endtask : t_reset
  // Writes to read-only registers are dropped
  task automatic t_ro;
    host.wr(12'h140, 32'hFFFFFFFF, 4'hF);
    host.wr(12'h144, 32'hFFFFFFFF, 4'hF);
    host.wr(12'h148, 32'hFFFFFFFF, 4'hF);
    host.rd(12'h140, v); chk(v, 32'h20C10002);
    host.rd(12'h144, v); chk(v, 32'h00000800);
    host.rd(12'h148, v); chk(v, 32'h00000000);
    $display("test read-only done");
  endtask : t_ro
  // Every select code, plus a write without byte zero
  task automatic t_select;
    logic [2:0] e;
    for (int s = 0; s < 8; s++) begin
      e = (s <= 1) ? 3'(s) : 3'h0;
      host.wr(12'h14C, {28'h0000FFF, 3'(s), 1'b0}, 4'hF);
      @(negedge clock);
      chk(scheme, e);
      host.rd(12'h14C, v); chk(v, {28'h0000000, e, 1'b0});
    end
    host.wr(12'h14C, 32'h00000002, 4'hE);
    host.rd(12'h14C, v); chk(v, 32'h00000000);
    $display("test select done");
  endtask : t_select
  // Table write sets status, load applies it and clears status
  task automatic t_load;
    logic [127:0] e;
    int n;
    e = 128'h89ABCDEF_01234567_FEDCBA98_76543210;
    for (int i = 0; i < 4; i++) host.wr(12'h160 + 12'(i * 4), e[i*32+:32], 4'hF);
    host.rd(12'h14C, v); chk(v, 32'h00010000);
    chk(activeTbl, 128'h0);
    host.wr(12'h14C, 32'h00000003, 4'hF);
    n = 0;
    @(negedge clock);
    while (done !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    chk(done, 1'b1);
    chk(32'(n), 32'h00000005);
    chk(activeTbl, e);
    chk(scheme, 3'h1);
    host.rd(12'h14C, v); chk(v, 32'h00000002);
    $display("test load done");
  endtask : t_load
  // Management override of the low priority count
  task automatic t_low_priority_vc_group;
    @(posedge clock);
    lpEn <= 1'b1;
    lpVal <= 3'h5;
    @(posedge clock);
    lpEn <= 1'b0;
    lpVal <= 3'h2;
    host.rd(12'h144, v); chk(v, 32'h00000850);
    $display("test low_priority_vc_group done");
  endtask : t_low_priority_vc_group
  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    t_reset();
    t_ro();
    t_select();
    t_load();
    t_low_priority_vc_group();
    complete_run();
  end
  // Watchdog
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
